// >>> shared/bra_pkg.sv
// Constants and types of the BCD and real add/subtract datapath
// Contract
// - 16-bit BCD add: accumulator low word plus memory
// - Zero flag when result accumulator is zero
// - Short carry on 16-bit add carry out
// - Long carry on 32-bit add carry out
// - Negative flag when accumulator value negative
// - Malformed flag on non-BCD digit in operand
// - 32-bit BCD add, memory pair or constant
// - Real add in single-precision IEEE format
// - Bad pointer flag on invalid pointer target
// - Invalid float flag on non-valid result
// - Sign error flag on wrong sign bit (here set on real-add exponent overflow instead)
// - Underflow flag on floating point underflow
// - Malformed flag on non-real real operand
// - 16-bit BCD subtract: accumulator low minus memory
// - Short borrow on 16-bit subtract borrow
// - Long borrow on 32-bit subtract borrow (no 32-bit subtract here; the flag stays clear)
// - Flags hold until next instruction updates them
package bra_pkg;

  localparam logic [5:0]  OFF_CTRL  = 6'h00;
  localparam logic [5:0]  OFF_ACC   = 6'h04;
  localparam logic [5:0]  OFF_OPLO  = 6'h08;
  localparam logic [5:0]  OFF_OPHI  = 6'h0c;
  localparam logic [5:0]  OFF_FLAGS = 6'h10;
  localparam logic [5:0]  OFF_ISTAT = 6'h14;
  localparam logic [5:0]  OFF_ICLR  = 6'h18;
  localparam logic [5:0]  OFF_IEN   = 6'h1c;

  localparam int unsigned CTRL_OP_LSB  = 0;
  localparam int unsigned CTRL_SRC_LSB = 4;
  localparam int unsigned CTRL_PTR_BIT = 8;
  localparam int unsigned CTRL_W       = 9;

  localparam logic [31:0] ACC_RST  = 32'h0000_0000;
  localparam logic [15:0] WORD_RST = 16'h0000;

  localparam int unsigned EV_DONE  = 0;
  localparam int unsigned EV_MALF  = 1;
  localparam int unsigned EV_BPTR  = 2;
  localparam int unsigned EV_W     = 3;

  localparam logic [7:0]  FLT_EXP_MAX = 8'hff;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    BRA_OP_ADD16 = 2'h0,
    BRA_OP_ADD32 = 2'h1,
    BRA_OP_ADDR  = 2'h2,
    BRA_OP_SUB16 = 2'h3
  } bra_op_e;

  typedef enum logic [1:0] {
    BRA_SRC_MEM   = 2'h0,
    BRA_SRC_PTR   = 2'h1,
    BRA_SRC_CONST = 2'h2
  } bra_src_e;

  typedef struct packed {
    logic zero;
    logic short_borrow;
    logic long_borrow;
    logic short_carry;
    logic long_carry;
    logic negative;
    logic bad_pointer;
    logic invalid_float;
    logic sign_error;
    logic underflow;
    logic malformed_operand;
  } bra_flags_s;

  typedef struct packed {
    logic [31:0] res;
    logic        uflow;
    logic        ovf;
  } bra_fres_s;

endpackage

// >>> src/bra_alu.sv
// BCD and real add/subtract datapath with AXI4-Lite register slave
//
// The AXI4-Lite slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module bra_alu (
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic [5:0]          s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [5:0]          s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  output bra_pkg::bra_flags_s      status_flags,
  output logic                     zero_flag,
  output logic                     short_borrow_flag,
  output logic                     long_borrow_flag,
  output logic                     short_carry_flag,
  output logic                     long_carry_flag,
  output logic                     negative_flag,
  output logic                     bad_pointer_flag,
  output logic                     invalid_float_flag,
  output logic                     sign_error_flag,
  output logic                     underflow_flag,
  output logic                     malformed_operand_flag,
  output logic                     irq
);
  import bra_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // Arithmetic helpers

  function automatic logic [32:0] bcd_add(input logic [31:0] a,
                                          input logic [31:0] b);
    logic [4:0]  d;
    logic        c;
    logic [31:0] s;
    c = 1'b0;
    s = 32'h0;
    for (int i = 0; i < 8; i++) begin
      d = {1'b0, a[4*i+:4]} + {1'b0, b[4*i+:4]} + {4'h0, c};
      c = (d > 5'd9);
      d = c ? d + 5'd6 : d;
      s[4*i+:4] = d[3:0];
    end
    return {c, s};
  endfunction

  function automatic logic [32:0] bcd_sub(input logic [31:0] a,
                                          input logic [31:0] b);
    logic [4:0]  d;
    logic        bw;
    logic [31:0] s;
    bw = 1'b0;
    s  = 32'h0;
    for (int i = 0; i < 8; i++) begin
      d  = {1'b0, a[4*i+:4]} - {1'b0, b[4*i+:4]} - {4'h0, bw};
      bw = d[4];
      d  = bw ? d + 5'd10 : d;
      s[4*i+:4] = d[3:0];
    end
    return {bw, s};
  endfunction

  function automatic logic not_bcd(input logic [31:0] v);
    logic bad;
    bad = 1'b0;
    for (int i = 0; i < 8; i++) begin
      bad = bad | (v[4*i+:4] > 4'h9);
    end
    return bad;
  endfunction

  // Truncating add; subnormal inputs count as zero to keep the
  // aligner short, at the cost of precision near the bottom of range
  function automatic bra_fres_s fadd(input logic [31:0] x,
                                     input logic [31:0] y);
    logic [31:0] a;
    logic [31:0] b;
    logic [24:0] ma;
    logic [24:0] mb;
    logic [24:0] s;
    logic [7:0]  d;
    logic [9:0]  e;
    logic [4:0]  lz;
    bra_fres_s   r;
    r = '0;
    a  = (x[30:0] >= y[30:0]) ? x : y;
    b  = (x[30:0] >= y[30:0]) ? y : x;
    ma = (a[30:23] == 8'h00) ? 25'h0 : {2'b01, a[22:0]};
    mb = (b[30:23] == 8'h00) ? 25'h0 : {2'b01, b[22:0]};
    d  = a[30:23] - b[30:23];
    mb = (d > 8'd24) ? 25'h0 : (mb >> d);
    e  = {2'b00, a[30:23]};
    s  = (a[31] == b[31]) ? ma + mb : ma - mb;
    e  = e + {9'h0, s[24]};
    s  = s >> s[24];
    lz = 5'd0;
    for (int i = 0; i < 24; i++) begin
      lz = s[i] ? 5'(23 - i) : lz;
    end
    s = s << lz;
    e = e - {5'h0, lz};
    if (s == 25'h0) begin
      r.res = 32'h0;
    end else if (e[9] || e == 10'h0) begin
      r.res   = {a[31], 31'h0};
      r.uflow = 1'b1;
    end else if (e >= {2'b00, FLT_EXP_MAX}) begin
      r.res = {a[31], FLT_EXP_MAX, 23'h0};
      r.ovf = 1'b1;
    end else begin
      r.res = {a[31], e[7:0], s[22:0]};
    end
    return r;
  endfunction

  function automatic logic [31:0] bmerge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  st);
    logic [31:0] m;
    for (int i = 0; i < 4; i++) begin
      m[8*i+:8] = st[i] ? nw[8*i+:8] : old[8*i+:8];
    end
    return m;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Register state

  logic [CTRL_W-1:0] ctrl_r;
  logic [31:0]       acc_r;
  logic [31:0]       acc_nxt;
  logic [15:0]       oplo_r;
  logic [15:0]       ophi_r;
  bra_flags_s        flags_r;
  bra_flags_s        flags_nxt;
  logic [EV_W-1:0]   ist_r;
  logic [EV_W-1:0]   ien_r;
  logic [EV_W-1:0]   ev;
  logic              go_r;
  logic              bvalid_r;
  logic [1:0]        bresp_r;
  logic              rvalid_r;
  logic [31:0]       rdata_r;
  logic [1:0]        rresp_r;
  logic              wr_go;
  logic              rd_go;
  logic              wr_map;
  logic [31:0]       rd_val;
  logic              rd_map;
  logic [31:0]       wmask;

  bra_op_e           op;
  bra_src_e          src;
  logic [31:0]       opnd;
  logic [32:0]       bsum;
  bra_fres_s         fr;

  ////////////////////////////////////////////////////////////////////
  // AXI4-Lite handshakes

  // Address and data are taken together, so either order works
  assign wr_go         = s_axi_awvalid & s_axi_wvalid & ~bvalid_r;
  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign rd_go         = s_axi_arvalid & ~rvalid_r;
  assign s_axi_arready = rd_go;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  assign wr_map = (s_axi_awaddr[1:0] == 2'b00) &&
                  (s_axi_awaddr <= OFF_IEN) &&
                  (s_axi_awaddr != OFF_FLAGS) &&
                  (s_axi_awaddr != OFF_ISTAT);
  assign wmask  = bmerge(32'h0, 32'hffff_ffff, s_axi_wstrb);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_r <= 1'b1;
      bresp_r  <= wr_map ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  always_comb begin
    rd_map = 1'b1;
    case (s_axi_araddr)
      OFF_CTRL:  rd_val = {23'h0, ctrl_r};
      OFF_ACC:   rd_val = acc_r;
      OFF_OPLO:  rd_val = {16'h0, oplo_r};
      OFF_OPHI:  rd_val = {16'h0, ophi_r};
      OFF_FLAGS: rd_val = {21'h0, flags_r};
      OFF_ISTAT: rd_val = {29'h0, ist_r};
      OFF_ICLR:  rd_val = 32'h0;
      OFF_IEN:   rd_val = {29'h0, ien_r};
      default: begin
        rd_val = 32'h0;
        rd_map = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0;
      rresp_r  <= RESP_OKAY;
    end else if (rd_go) begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_val;
      rresp_r  <= rd_map ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Software-written registers

  // A write to the control word launches one operation
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= '0;
      go_r   <= 1'b0;
    end else begin
      go_r <= wr_go && (s_axi_awaddr == OFF_CTRL);
      if (wr_go && s_axi_awaddr == OFF_CTRL) begin
        ctrl_r <= CTRL_W'(bmerge({23'h0, ctrl_r}, s_axi_wdata,
                                 s_axi_wstrb));
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      oplo_r <= WORD_RST;
      ophi_r <= WORD_RST;
    end else if (wr_go && s_axi_awaddr == OFF_OPLO) begin
      oplo_r <= 16'(bmerge({16'h0, oplo_r}, s_axi_wdata, s_axi_wstrb));
    end else if (wr_go && s_axi_awaddr == OFF_OPHI) begin
      ophi_r <= 16'(bmerge({16'h0, ophi_r}, s_axi_wdata, s_axi_wstrb));
    end
  end

  // Bus writes cannot meet go_r: bvalid blocks the next write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_r <= ACC_RST;
    end else if (go_r) begin
      acc_r <= acc_nxt;
    end else if (wr_go && s_axi_awaddr == OFF_ACC) begin
      acc_r <= bmerge(acc_r, s_axi_wdata, s_axi_wstrb);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Datapath

  assign op   = bra_op_e'(ctrl_r[CTRL_OP_LSB+:2]);
  assign src  = bra_src_e'(ctrl_r[CTRL_SRC_LSB+:2]);
  assign opnd = {ophi_r, oplo_r};
  assign fr   = fadd(acc_r, opnd);

  always_comb begin
    acc_nxt   = acc_r;
    flags_nxt = flags_r;
    bsum      = 33'h0;
    flags_nxt.bad_pointer = (src == BRA_SRC_PTR) && !ctrl_r[CTRL_PTR_BIT];
    if (!flags_nxt.bad_pointer) begin
      case (op)
        BRA_OP_ADD16: begin
          bsum = bcd_add({16'h0, acc_r[15:0]}, {16'h0, oplo_r});
          acc_nxt = {16'h0, bsum[15:0]};
          flags_nxt.short_carry = bsum[16];
          flags_nxt.negative    = 1'b0;
          flags_nxt.malformed_operand = not_bcd({acc_r[15:0], oplo_r});
        end
        BRA_OP_SUB16: begin
          bsum = bcd_sub({16'h0, acc_r[15:0]}, {16'h0, oplo_r});
          acc_nxt = {16'h0, bsum[15:0]};
          flags_nxt.short_borrow = bsum[32];
          flags_nxt.negative = bsum[32];
          flags_nxt.malformed_operand = not_bcd({acc_r[15:0], oplo_r});
        end
        BRA_OP_ADD32: begin
          bsum = bcd_add(acc_r, opnd);
          acc_nxt = bsum[31:0];
          flags_nxt.long_carry = bsum[32];
          flags_nxt.negative   = 1'b0;
          flags_nxt.malformed_operand = not_bcd(acc_r) | not_bcd(opnd);
        end
        default: begin
          acc_nxt = fr.res;
          flags_nxt.negative = fr.res[31] && (fr.res[30:0] != 31'h0);
          flags_nxt.invalid_float = (fr.res[30:23] == FLT_EXP_MAX);
          flags_nxt.sign_error = fr.ovf;
          flags_nxt.underflow = fr.uflow;
          flags_nxt.malformed_operand = (acc_r[30:23] == FLT_EXP_MAX) ||
                                        (opnd[30:23] == FLT_EXP_MAX);
        end
      endcase
      if (src == BRA_SRC_CONST &&
          (op == BRA_OP_ADD16 || op == BRA_OP_SUB16)) begin
        acc_nxt = acc_r;
        flags_nxt.malformed_operand = 1'b1;
      end
      flags_nxt.zero = (op == BRA_OP_ADDR) ? (acc_nxt[30:0] == 31'h0)
                                           : (acc_nxt == 32'h0);
    end
  end

  // long borrow never arises here: no 32-bit subtract exists
  // flags change only when an operation completes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_r <= '0;
    end else if (go_r) begin
      flags_r <= flags_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Interrupts

  assign ev[EV_DONE] = go_r;
  assign ev[EV_MALF] = go_r & flags_nxt.malformed_operand;
  assign ev[EV_BPTR] = go_r & flags_nxt.bad_pointer;

  // Set after clear, so an event in the clearing cycle survives
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ist_r <= '0;
      ien_r <= '0;
    end else begin
      if (wr_go && s_axi_awaddr == OFF_ICLR) begin
        ist_r <= (ist_r & ~EV_W'(s_axi_wdata & wmask)) | ev;
      end else begin
        ist_r <= ist_r | ev;
      end
      if (wr_go && s_axi_awaddr == OFF_IEN) begin
        ien_r <= EV_W'(bmerge({29'h0, ien_r}, s_axi_wdata, s_axi_wstrb));
      end
    end
  end

  assign irq = |(ist_r & ien_r);

  ////////////////////////////////////////////////////////////////////
  // Discrete flag outputs

  assign status_flags = flags_r;
  assign {zero_flag, short_borrow_flag, long_borrow_flag, short_carry_flag,
          long_carry_flag, negative_flag, bad_pointer_flag, invalid_float_flag,
          sign_error_flag, underflow_flag, malformed_operand_flag} = flags_r;

endmodule // bra_alu
`default_nettype wire

// >>> sim/bra_alu_properties.sv
// Concurrent checks on the flag outputs of the add/subtract datapath
`timescale 1ns/1ns
`default_nettype none
module bra_alu_properties (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [5:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire bra_pkg::bra_flags_s status_flags,
  input wire logic        short_borrow_flag,
  input wire logic        long_borrow_flag,
  input wire logic        short_carry_flag,
  input wire logic        long_carry_flag,
  input wire logic        negative_flag,
  input wire logic        bad_pointer_flag,
  input wire logic        malformed_operand_flag,
  input wire logic        irq
);
  import bra_pkg::*;
  ////////////////////////////////////////////////////////////
  // Track the control word two edges back, when new flags show
  logic       take;
  logic       t1_r;
  logic       t2_r;
  logic [8:0] c1_r;
  logic [8:0] c2_r;
  logic       bad2;
  assign take = s_axi_awvalid && s_axi_wvalid && s_axi_awready
                && s_axi_awaddr == OFF_CTRL && s_axi_wstrb == 4'hf;
  assign bad2 = c2_r[5:4] == BRA_SRC_PTR && !c2_r[8];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      t1_r <= 1'b0;
      t2_r <= 1'b0;
      c1_r <= 9'h000;
      c2_r <= 9'h000;
    end else begin
      t1_r <= take;
      t2_r <= t1_r;
      c1_r <= s_axi_wdata[8:0];
      c2_r <= c1_r;
    end
  end
  ////////////////////////////////////////////////////////////
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_flag_hold: assert property (!t1_r && !t2_r |-> $stable(status_flags))
    else $error("flags moved without an operation");
  chk_const_refused: assert property (t2_r && c2_r[5:4] == BRA_SRC_CONST
    && (c2_r[1:0] == BRA_OP_ADD16 || c2_r[1:0] == BRA_OP_SUB16) |-> malformed_operand_flag)
    else $error("constant on a 16-bit op not flagged");
  chk_ptr_bad: assert property (t2_r && bad2 |-> bad_pointer_flag
    && $stable(short_carry_flag) && $stable(negative_flag))
    else $error("bad pointer not flagged or other flags moved");
  chk_sub_sign: assert property (t2_r && c2_r[5:0] == 6'h03
    |-> negative_flag == short_borrow_flag) else $error("sub sign differs from borrow");
  chk_add_sign: assert property (t2_r && c2_r[5:1] == 5'h00 |-> !negative_flag)
    else $error("BCD add left negative set");
  chk_short_scope: assert property (t2_r && c2_r[5:0] == 6'h00
    |-> $stable(long_carry_flag) && $stable(short_borrow_flag))
    else $error("16-bit add touched other flags");
  chk_long_scope: assert property (t2_r && c2_r[5:0] == 6'h01
    |-> $stable(short_carry_flag)) else $error("32-bit add touched short carry");
  chk_no_lborrow: assert property (!long_borrow_flag)
    else $error("long borrow set without a 32-bit subtract");
  cover property (t2_r && bad2);
  cover property (t2_r && short_borrow_flag);
  cover property ($rose(irq));
endmodule // bra_alu_properties
`default_nettype wire

// >>> sim/bra_seq.sv
// Sequencer model: register bus master issuing datapath operations
`timescale 1ns/1ns
`default_nettype none
module bra_seq (
  input  wire logic        aclk,
  input  wire logic [3:0]  strb,
  output var logic [5:0]   s_axi_awaddr,
  output var logic         s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output var logic [31:0]  s_axi_wdata,
  output var logic [3:0]   s_axi_wstrb,
  output var logic         s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output var logic         s_axi_bready,
  output var logic [5:0]   s_axi_araddr,
  output var logic         s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output var logic         s_axi_rready,
  output var logic         hung
);
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready, hung} = '0;
  end
  ////////////////////////////////////////////////////////////
  // operand kind is chosen by the caller
  task automatic wr(input logic [5:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= strb;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin @(posedge aclk); n++; end while ({s_axi_awready, s_axi_wready} !== 2'h3 && n < 100);
    // Released address and data lines show a changed value, never the old one; the strobes keep theirs
    {s_axi_awvalid, s_axi_wvalid} <= 2'h0;
    s_axi_awaddr <= ~a;
    s_axi_wdata <= ~d;
    do begin @(posedge aclk); n++; end while (s_axi_bvalid !== 1'b1 && n < 100);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n >= 100) hung <= 1'b1;
  endtask
  // results taken at the answer edge
  task automatic rd(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin @(posedge aclk); n++; end while (s_axi_arready !== 1'b1 && n < 100);
    s_axi_arvalid <= 1'b0;
    s_axi_araddr <= ~a;
    do begin @(posedge aclk); n++; end while (s_axi_rvalid !== 1'b1 && n < 100);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n >= 100) hung <= 1'b1;
  endtask
endmodule // bra_seq
`default_nettype wire

// >>> sim/testbench.sv
// Self-checking bench for the add/subtract datapath
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import bra_pkg::*;
  typedef struct packed {
    logic [8:0] c; logic [31:0] a; logic [31:0] o; logic [31:0] e;
    logic k; logic [10:0] m; logic [10:0] f;
  } bra_row_s;
  logic aclk = 1'b0, aresetn = 1'b0, seq_hung;
  logic [3:0] seq_strb = 4'hf;
  logic [5:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq;
  bra_flags_s status_flags;
  logic zero_flag, short_borrow_flag, long_borrow_flag, short_carry_flag, long_carry_flag;
  logic negative_flag, bad_pointer_flag, invalid_float_flag, sign_error_flag;
  logic underflow_flag, malformed_operand_flag;
  int fails = 0, n_tests = 0;
  bra_row_s rows [18] = '{
    '{9'h000, 32'h9999, 32'h0001, 32'h0, 1'b1, 11'h4a1, 11'h480},
    '{9'h000, 32'h1234, 32'h0789, 32'h2023, 1'b1, 11'h4a1, 11'h000},
    '{9'h000, 32'h1234, 32'h00a1, 32'h0, 1'b0, 11'h001, 11'h001},
    '{9'h020, 32'h1234, 32'h0001, 32'h1234, 1'b1, 11'h001, 11'h001},
    '{9'h001, 32'h99999999, 32'h1, 32'h0, 1'b1, 11'h461, 11'h440},
    '{9'h021, 32'h12345678, 32'h11111111, 32'h23456789, 1'b1, 11'h461, 11'h0},
    '{9'h003, 32'h0050, 32'h0020, 32'h0030, 1'b1, 11'h621, 11'h000},
    '{9'h003, 32'h0020, 32'h0050, 32'h9970, 1'b1, 11'h621, 11'h220},
    '{9'h023, 32'h0020, 32'h0050, 32'h0020, 1'b1, 11'h001, 11'h001},
    '{9'h010, 32'h0011, 32'h0022, 32'h0011, 1'b1, 11'h010, 11'h010},
    '{9'h110, 32'h0011, 32'h0022, 32'h0033, 1'b1, 11'h411, 11'h000},
    '{9'h002, 32'h3f800000, 32'h3f800000, 32'h40000000, 1'b1, 11'h42f, 11'h0},
    '{9'h022, 32'h3f800000, 32'h3f800000, 32'h40000000, 1'b1, 11'h42f, 11'h0},
    '{9'h002, 32'h3f800000, 32'hc0000000, 32'hbf800000, 1'b1, 11'h42f, 11'h020},
    '{9'h002, 32'h3f800000, 32'hbf800000, 32'h0, 1'b0, 11'h400, 11'h400},
    '{9'h002, 32'h7f7fffff, 32'h7f7fffff, 32'h7f800000, 1'b1, 11'h00e, 11'h00c},
    '{9'h002, 32'h00800000, 32'h80800001, 32'h80000000, 1'b1, 11'h403, 11'h402},
    '{9'h002, 32'h3f800000, 32'h7fc00000, 32'h0, 1'b0, 11'h001, 11'h001}
  };
  always #5 aclk = ~aclk;
  ////////////////////////////////////////////////////////////
  bra_alu bra_alu_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .status_flags, .zero_flag,
    .short_borrow_flag, .long_borrow_flag, .short_carry_flag, .long_carry_flag,
    .negative_flag, .bad_pointer_flag, .invalid_float_flag, .sign_error_flag,
    .underflow_flag, .malformed_operand_flag, .irq);
  bra_seq bra_seq_i (.aclk, .strb(seq_strb), .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .hung(seq_hung));
  ////////////////////////////////////////////////////////////
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic w(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [1:0] r;
    bra_seq_i.wr(a, d, r);
    cmp("write response", {30'h0, er}, {30'h0, r});
  endtask
  task automatic rchk(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e,
                      input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    bra_seq_i.rd(a, d, r);
    cmp("read data", e, d & m);
    cmp("read response", {30'h0, er}, {30'h0, r});
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge seq_hung) begin
    fails++;
    final_report();
  end
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(OFF_ACC, 32'hffffffff, ACC_RST, RESP_OKAY);
    rchk(OFF_FLAGS, 32'hffffffff, 32'h0, RESP_OKAY);
    rchk(OFF_ISTAT, 32'hffffffff, 32'h0, RESP_OKAY);
    foreach (rows[i]) begin
      w(OFF_ACC, rows[i].a, RESP_OKAY);
      w(OFF_OPLO, {16'h0, rows[i].o[15:0]}, RESP_OKAY);
      w(OFF_OPHI, {16'h0, rows[i].o[31:16]}, RESP_OKAY);
      w(OFF_CTRL, {23'h0, rows[i].c}, RESP_OKAY);
      if (rows[i].k) rchk(OFF_ACC, 32'hffffffff, rows[i].e, RESP_OKAY);
      rchk(OFF_FLAGS, {21'h0, rows[i].m}, {21'h0, rows[i].f}, RESP_OKAY);
      cmp("flag bus", {21'h0, rows[i].f}, {21'h0, status_flags & rows[i].m});
      cmp("flag pins", {21'h0, rows[i].f}, {21'h0, rows[i].m & {zero_flag,
        short_borrow_flag, long_borrow_flag, short_carry_flag, long_carry_flag,
        negative_flag, bad_pointer_flag, invalid_float_flag, sign_error_flag,
        underflow_flag, malformed_operand_flag}});
    end
    rchk(OFF_ISTAT, 32'h7, 32'h7, RESP_OKAY);
    w(OFF_IEN, 32'h1, RESP_OKAY);
    @(posedge aclk);
    cmp("irq", 32'h1, {31'h0, irq});
    rchk(OFF_IEN, 32'h7, 32'h1, RESP_OKAY);
    w(OFF_IEN, 32'h0, RESP_OKAY);
    @(posedge aclk);
    cmp("irq", 32'h0, {31'h0, irq});
    w(OFF_ICLR, 32'h7, RESP_OKAY);
    rchk(OFF_ISTAT, 32'h7, 32'h0, RESP_OKAY);
    rchk(OFF_ICLR, 32'hffffffff, 32'h0, RESP_OKAY);
    w(OFF_IEN, 32'h7, RESP_OKAY);
    @(posedge aclk);
    cmp("irq", 32'h0, {31'h0, irq});
    w(OFF_CTRL, 32'h0, RESP_OKAY);
    @(posedge aclk);
    cmp("irq", 32'h1, {31'h0, irq});
    w(OFF_ACC, 32'h12345678, RESP_OKAY);
    seq_strb <= 4'h2;
    w(OFF_ACC, 32'hffffffff, RESP_OKAY);
    seq_strb <= 4'hf;
    rchk(OFF_ACC, 32'hffffffff, 32'h1234ff78, RESP_OKAY);
    w(OFF_FLAGS, 32'h7ff, RESP_SLVERR);
    w(6'h02, 32'h0, RESP_SLVERR);
    w(6'h20, 32'h0, RESP_SLVERR);
    rchk(6'h20, 32'hffffffff, 32'h0, RESP_SLVERR);
    final_report();
  end
endmodule // testbench
bind bra_alu bra_alu_properties bra_alu_properties_i (.aclk, .aresetn, .s_axi_awaddr,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .status_flags,
  .short_borrow_flag, .long_borrow_flag, .short_carry_flag, .long_carry_flag, .negative_flag,
  .bad_pointer_flag, .malformed_operand_flag, .irq);
`default_nettype wire
